/* bench/rf_feedback_divider_word_tb.sv */
/* Self-checking bench for the divider word receiver.
   Assumes the serial_host model drives the pins and the bench drives the rest. */
`timescale 1ns/1ps
module rf_feedback_divider_word_tb;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic psc = 1'h0;
    logic auto_pu = 1'h0;
    logic pd_wr = 1'h0;
    logic pd_val = 1'h0;
    wire sd, sc, sl;
    rf_div_pkg::div_setting_t setting;
    logic [10:0] n_int;
    logic [11:0] div_val;
    logic applied, aux_pd, hit;
    int failures = 0;
    int comparisons = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #10 clock = ~clock;
    serial_host host (.clock(clock), .ser_data(sd), .ser_clk(sc), .ser_latch(sl));
    rf_feedback_divider_word DUT (.clock(clock), .rst_n(rst_n), .ser_data(sd),
        .ser_clk(sc), .ser_latch(sl), .rf_prescaler_select(psc),
        .auto_powerup_on_write(auto_pu), .aux_pd_write(pd_wr), .aux_pd_value(pd_val),
        .setting(setting), .rf_integer_divide(n_int), .divide_value(div_val),
        .word_applied(applied), .aux_loop_powerdown(aux_pd));
    ////////////////////////////////////////////////////////////////////////////
    // Compares one observed value with its expectation.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Sends a word while watching, under a bound, for the applied pulse.
    task automatic write_word(input logic [10:0] n, input logic [11:0] f, input logic sel);
        hit = 1'h0;
        fork
            host.send_word({n, f, sel});
            for (int k = 0; k < 300 && !hit; k++) begin
                @(posedge clock);
                #1 hit = (applied === 1'h1);
            end
        join
        repeat (2) @(negedge clock);
    endtask
    // Writes C, B, A and checks the decoded fields and the divide value.
    task automatic word_case(input logic [5:0] c, input logic [2:0] b, input logic [1:0] a,
                             input logic [11:0] f);
        int base;
        base = (psc === 1'h1) ? 32 : 16;
        write_word({c, b, a}, f, 1'h0);
        check(hit, 1'h1);
        check(n_int, {c, b, a});
        check(setting, {c, b, a, f, ~psc});
        check(div_val, 12'(base * c + 4 * b + a));
    endtask
    // Small prescaler, divide 70 in the upper band, then 57 in the lower band.
    task automatic test_small();
        psc = 1'h0;
        word_case(6'h04, 3'h1, 2'h2, 12'h5a3);
        word_case(6'h03, 3'h2, 2'h1, 12'ha5c);
    endtask
    // Large prescaler, divide 228 where fourth order is barred, then 105.
    task automatic test_large();
        psc = 1'h1;
        word_case(6'h07, 3'h1, 2'h0, 12'h0f0);
        word_case(6'h03, 3'h2, 2'h1, 12'h3c1);
    endtask
    // A word whose select bit is one must leave every field untouched.
    task automatic test_refused();
        write_word(11'h7ff, 12'hfff, 1'h1);
        check(hit, 1'h0);
        check(n_int, 11'h069);
        check(setting.frac_low, 12'h3c1);
    endtask
    // Power-down survives a plain write and clears on an auto-powerup write.
    task automatic test_powerup();
        @(negedge clock) pd_wr = 1'h1;
        pd_val = 1'h1;
        @(negedge clock) pd_wr = 1'h0;
        write_word(11'h06d, 12'h001, 1'h0);
        check(aux_pd, 1'h1);
        auto_pu = 1'h1;
        write_word(11'h06d, 12'h002, 1'h0);
        check(aux_pd, 1'h0);
    endtask
    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well beyond the seven words the run sends.
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        repeat (2) @(negedge clock);
        rst_n = 1'h1;
        test_small();
        test_large();
        test_refused();
        test_powerup();
        print_verdict();
    end
endmodule

/* bench/serial_host.sv */
/* Host model that programs the divider word over the three-wire link.
   Assumes a 20 ns core clock; pins change only on its falling edge. */
`timescale 1ns/1ps
module serial_host (
    // Core clock used for pacing.
    input wire logic clock,
    // Serial programming pins.
    output logic ser_data,
    output logic ser_clk,
    output logic ser_latch
);
    // The serial clock stands still low outside frames.
    initial begin
        ser_data = 1'h0;
        ser_clk = 1'h0;
        ser_latch = 1'h0;
    end
    // Each pin phase lasts at least four cycles, above the three-cycle minimum the pins need.
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge clock) ser_data = w[i];
            repeat (4) @(negedge clock);
            ser_clk = 1'h1;
            repeat (4) @(negedge clock);
            ser_clk = 1'h0;
        end
        repeat (4) @(negedge clock);
        ser_latch = 1'h1;
        repeat (4) @(negedge clock);
        ser_latch = 1'h0;
        // Released data flips so a stale bit is never mistaken for a held one.
        ser_data = ~ser_data;
    endtask
endmodule

/* common/rf_div_pkg.sv */
/*
 * Shared constants and carrier types for the RF feedback divider word block.
 * Assumes a 24-bit serial word, shifted in most significant bit first.
 */
package rf_div_pkg;
    // Serial word geometry.
    localparam int WORD_W = 24;
    localparam int SEL_BIT = 0;
    localparam logic SEL_VALUE = 1'h0;
    localparam int FRAC_LO = 1;
    localparam int FRAC_W = 12;
    localparam int INT_LO = 13;
    localparam int INT_W = 11;
    // Integer field sub-fields.
    localparam int C_LO = 5;
    localparam int C_W = 6;
    localparam int B_LO = 2;
    localparam int B_W = 3;
    localparam int A_LO = 0;
    localparam int A_W = 2;
    // Prescaler base moduli and the B weight.
    localparam logic [5:0] BASE_SMALL = 6'h10;
    localparam logic [5:0] BASE_LARGE = 6'h20;
    localparam logic [2:0] B_WEIGHT = 3'h4;
    localparam logic PSC_SMALL = 1'h0;
    localparam logic PSC_LARGE = 1'h1;
    // Bit counter width.
    localparam int CNT_W = 5;

    // Decoded divider setting that leaves the block.
    typedef struct packed {
        logic [5:0] cycle_count;
        logic [2:0] four_count;
        logic [1:0] unit_count;
        logic [11:0] frac_low;
        logic spare_b_bit;
    } div_setting_t;
endpackage

/* hdl/rf_feedback_divider_word.sv */
/*
 * Device-side receiver for the RF feedback divider control word.
 * Assumes the host drives a three-wire link (data, clock, latch enable)
 * asynchronously; all three pins are synchronised to the core clock.
 */
`timescale 1ns/1ps

// Behaviour
// R1: bit zero low selects this word
// R2: low twelve payload bits are fraction low
// R3: two four-modulus prescalers, small and large
// R4: divide equals base times C plus 4B plus A
// R5: host keeps C at least max of A, B
// R6: spare B bit goes to modulator
// R7: host limits small prescaler range 49 to 1023
// R8: host limits fourth order 64 to 75
// R9: host limits large prescaler range 97 to 2045
// R10: host avoids fourth order at 227-230
// R11: select zero small prescaler, one large
// R12: auto powerup clears aux powerdown on write
// R13: C B A split, applied after write completes
module rf_feedback_divider_word (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Serial programming pins.
    input wire logic ser_data,
    input wire logic ser_clk,
    input wire logic ser_latch,
    // Configuration held elsewhere in the device.
    input wire logic rf_prescaler_select,
    input wire logic auto_powerup_on_write,
    input wire logic aux_pd_write,
    input wire logic aux_pd_value,
    // Divider outputs.
    output rf_div_pkg::div_setting_t setting,
    output logic [10:0] rf_integer_divide,
    output logic [11:0] divide_value,
    output logic word_applied,
    output logic aux_loop_powerdown
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage read only by the second.
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] prev_ff;
    logic [2:0] nxt_sync1;

    // Registered pin samples; edges come from stage two and its delay.
    always_comb begin
        nxt_sync1 = {ser_latch, ser_clk, ser_data};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff <= 3'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    logic clk_rise;
    logic latch_rise;
    assign clk_rise = sync2_ff[1] & ~prev_ff[1];
    assign latch_rise = sync2_ff[2] & ~prev_ff[2];

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and word apply.
    logic [rf_div_pkg::WORD_W-1:0] shift_ff;
    logic [rf_div_pkg::WORD_W-1:0] nxt_shift;
    logic [10:0] int_ff;
    logic [10:0] nxt_int;
    logic [11:0] frac_ff;
    logic [11:0] nxt_frac;
    logic applied_ff;
    logic nxt_applied;
    logic aux_pd_ff;
    logic nxt_aux_pd;
    logic hit;

    // The word only counts when its selector bit is low; other words pass by.
    assign hit = latch_rise && (shift_ff[rf_div_pkg::SEL_BIT] == rf_div_pkg::SEL_VALUE); // R1

    // Shift on clock rise; the new value is taken only at the latch edge, so
    // a half-shifted word never reaches the divider.
    always_comb begin
        nxt_shift = shift_ff;
        nxt_int = int_ff;
        nxt_frac = frac_ff;
        nxt_applied = 1'h0;
        nxt_aux_pd = aux_pd_ff;
        if (clk_rise) begin
            nxt_shift = {shift_ff[rf_div_pkg::WORD_W-2:0], sync2_ff[0]};
        end
        if (aux_pd_write) begin
            nxt_aux_pd = aux_pd_value;
        end
        if (hit) begin
            nxt_int = shift_ff[rf_div_pkg::INT_LO +: rf_div_pkg::INT_W]; // R13
            nxt_frac = shift_ff[rf_div_pkg::FRAC_LO +: rf_div_pkg::FRAC_W]; // R2
            nxt_applied = 1'h1;
            // Auto powerup wins over a simultaneous register write.
            if (auto_powerup_on_write) begin
                nxt_aux_pd = 1'h0; // R12
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shift_ff <= '0;
            int_ff <= 11'h000;
            frac_ff <= 12'h000;
            applied_ff <= 1'h0;
            aux_pd_ff <= 1'h0;
        end else begin
            shift_ff <= nxt_shift;
            int_ff <= nxt_int;
            frac_ff <= nxt_frac;
            applied_ff <= nxt_applied;
            aux_pd_ff <= nxt_aux_pd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the held word into counter settings.
    logic [5:0] base;
    logic [5:0] c_cnt;
    logic [2:0] b_cnt;
    logic [1:0] a_cnt;
    logic [11:0] dv_ff;
    logic [11:0] nxt_dv;

    // Select low means the small 16/17/20/21 set, high the large 32/33/36/37.
    assign base = (rf_prescaler_select == rf_div_pkg::PSC_LARGE) ?
        rf_div_pkg::BASE_LARGE : rf_div_pkg::BASE_SMALL; // R3 R11
    assign c_cnt = int_ff[rf_div_pkg::C_LO +: rf_div_pkg::C_W]; // R13
    assign b_cnt = int_ff[rf_div_pkg::B_LO +: rf_div_pkg::B_W]; // R13
    assign a_cnt = int_ff[rf_div_pkg::A_LO +: rf_div_pkg::A_W]; // R13

    // Effective divide; host range limits are trusted, not checked here.
    always_comb begin
        // Every operand is widened first, so no product wraps at its own width.
        nxt_dv = 12'(base) * 12'(c_cnt) + 12'(rf_div_pkg::B_WEIGHT) * 12'(b_cnt)
            + 12'(a_cnt); // R4 R5
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dv_ff <= 12'h000;
        end else begin
            dv_ff <= nxt_dv;
        end
    end

    // With the small prescaler only B values 0..3 are in use, so the top B
    // bit is free, and spare_b_bit is driven high to offer it to the modulator.
    assign setting.cycle_count = c_cnt;
    assign setting.four_count = b_cnt;
    assign setting.unit_count = a_cnt;
    assign setting.frac_low = frac_ff;
    assign setting.spare_b_bit = (rf_prescaler_select == rf_div_pkg::PSC_SMALL); // R6
    assign rf_integer_divide = int_ff;
    assign divide_value = dv_ff;
    assign word_applied = applied_ff;
    assign aux_loop_powerdown = aux_pd_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    // The integer field lands from the shifted word one cycle after the take.
    a_apply_int: assert property (@(posedge clock) disable iff (!rst_n) // R13
        hit |=> (int_ff == $past(shift_ff[rf_div_pkg::INT_LO +: rf_div_pkg::INT_W])))
        else $error("integer field not applied");
    // The fraction field lands in the same cycle as the integer field.
    a_apply_frac: assert property (@(posedge clock) disable iff (!rst_n) // R2
        hit |=> (frac_ff == $past(shift_ff[rf_div_pkg::FRAC_LO +: rf_div_pkg::FRAC_W])))
        else $error("fraction field not applied");
    // A word for another register must leave both held fields alone.
    a_sel_ignore: assert property (@(posedge clock) disable iff (!rst_n) // R1
        (latch_rise && (shift_ff[rf_div_pkg::SEL_BIT] != rf_div_pkg::SEL_VALUE))
        |=> ($stable(int_ff) && $stable(frac_ff)))
        else $error("other word changed divider");
    // The applied pulse only ever follows a taken word.
    a_apply_pulse: assert property (@(posedge clock) disable iff (!rst_n) // R13
        word_applied |-> $past(hit))
        else $error("applied without write");

    // Auto powerup forces the aux loop on, whatever the register write says.
    a_auto_pwr: assert property (@(posedge clock) disable iff (!rst_n) // R12
        (hit && auto_powerup_on_write) |=> !aux_loop_powerdown)
        else $error("aux loop not powered up");
    // Without auto powerup a divider write must not touch the aux loop.
    a_no_auto: assert property (@(posedge clock) disable iff (!rst_n) // R12
        (hit && !auto_powerup_on_write && !aux_pd_write) |=> $stable(aux_loop_powerdown))
        else $error("aux powerdown changed");

    // Once inputs have settled for a cycle, the divide value is base C plus 4B plus A,
    // worked out here by shifts rather than by the products the datapath uses.
    a_divide_eq: assert property (@(posedge clock) disable iff (!rst_n) // R4
        ($stable(int_ff) && $stable(rf_prescaler_select)) |->
        (divide_value == (rf_prescaler_select ? 12'({c_cnt, 5'h00}) : 12'({c_cnt, 4'h0}))
            + 12'({b_cnt, 2'h0}) + 12'(a_cnt)))
        else $error("divide value wrong");
    // Select low picks the small base, select high the large one.
    a_psc_base: assert property (@(posedge clock) disable iff (!rst_n) // R11
        base == (rf_prescaler_select ? 6'h20 : 6'h10))
        else $error("prescaler base wrong");
    // The spare B bit is offered only while the small prescaler is in use.
    a_spare_bit: assert property (@(posedge clock) disable iff (!rst_n) // R6
        setting.spare_b_bit == !rf_prescaler_select)
        else $error("spare bit wrong");

    // A taken word and the single pulse that reports it, as two steps of one walk.
    sequence s_word_taken;
        latch_rise && (shift_ff[rf_div_pkg::SEL_BIT] == rf_div_pkg::SEL_VALUE);
    endsequence
    sequence s_word_reported;
        word_applied ##1 !word_applied;
    endsequence
    a_apply_walk: assert property (@(posedge clock) disable iff (!rst_n) // R13
        s_word_taken |=> s_word_reported)
        else $error("taken word not reported");
    // Between takes the held fields stay put, so a half-shifted word never leaks.
    a_hold_between: assert property (@(posedge clock) disable iff (!rst_n) // R13
        !hit |=> ($stable(int_ff) && $stable(frac_ff)))
        else $error("fields moved without a take");
endmodule
